// ===== src/dtc_pkg.sv
// package: constants and types of the software-triggered transfer control
package dtc_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] DTC_TRIG_OFS = 8'h00;
  localparam logic [7:0] DTC_CMD_OFS  = 8'h04;
  localparam logic [7:0] DTC_CFG_OFS  = 8'h08;
  localparam logic [7:0] DTC_MON_OFS  = 8'h0c;

  // trigger register fields
  localparam int DTC_PTR_W        = 16;
  localparam int DTC_TRIG_PEND_B  = 16;
  localparam int DTC_TRIG_DONE_B  = 17;

  // config register fields
  localparam int DTC_CFG_SW_PRIORITY_SEL_B   = 0;
  localparam int DTC_CFG_ERROR_STOP_ENABLE_B   = 1;

  // monitor register fields
  localparam int DTC_MON_DER_B    = 3;
  localparam int DTC_MON_STOP_B   = 4;
  localparam int DTC_MON_PTR_LSB  = 16;

  // command codes written to the command register
  localparam logic [7:0] DTC_CMD_SW_STATUS_CLEAR_CMD   = 8'h01;
  localparam logic [7:0] DTC_CMD_ERROR_CLEAR_CMD   = 8'h02;
  localparam logic [7:0] DTC_CMD_RELEASE = 8'h04;
  localparam logic [7:0] DTC_CMD_STANDBY = 8'h08;

  // device states as read from the command register
  localparam logic [1:0] DTC_ST_NORMAL  = 2'h0;
  localparam logic [1:0] DTC_ST_STANDBY = 2'h1;
  localparam logic [1:0] DTC_ST_TRANS1  = 2'h2;
  localparam logic [1:0] DTC_ST_TRANS2  = 2'h3;

  // values after reset
  localparam logic [2:0] DTC_EST_NONE   = 3'h0;
  localparam logic [1:0] DTC_CFG_RESET  = 2'h0;
  localparam logic [DTC_PTR_W-1:0] DTC_PTR_RESET = 16'h0000;

  // arbitration state machine, one-hot
  typedef enum logic [2:0] {
    DTC_ARB    = 3'b001,
    DTC_HW_RUN = 3'b010,
    DTC_SW_RUN = 3'b100
  } dtc_state_type;

  // result reported by the descriptor engine at the end of a descriptor
  typedef struct packed {
    logic [2:0]           err_code;   // 000 = normal end
    logic                 chain;      // chain start requested
    logic                 chain_lock; // chain is locked
    logic                 irq;        // interrupt flag set requested
    logic [DTC_PTR_W-1:0] desc_ptr;   // descriptor just executed
    logic [DTC_PTR_W-1:0] next_ptr;   // next descriptor of the chain
  } dtc_result_type;

endpackage

// ===== src/dtc_sw_ctrl.sv
// module: control of software-triggered descriptor transfers
//
// Overview of operation
// R1: only a trigger write starts software flow
// R2: accept if idle, no error stop, normal
// R3: rejected trigger write changes nothing
// R4: accept sets pending, clears done, latches pointer
// R5: software waits while hardware descriptor runs
// R6: priority bit chooses software or hardware first
// R7: low priority: hardware first, else software
// R8: hardware chain continues if locked, else rearbitrate
// R9: first error recorded, later sets double error
// R10: error stop holds pending until error clear
// R11: software transfer uses latched pointer
// R12: software chain overwrites pointer with next
// R13: locked chain runs at once, else rearbitrate
// R14: normal end with flag: clear pending, set done
// R15: normal end without flag: clear pending only
// R16: pointer keeps last descriptor until next accept
// R17: software error recorded, pending cleared
// R18: software error stop withholds hardware starts
// R19: software error never sets done
// R20: software clears done with clear command
// R21: trigger accepted while done set, clears it
// R22: software sets chain so done marks completion
// R23: trigger ignored outside normal state
// R24: error clear releases stop, arbitration resumes
// R25: monitor keeps only first error details
// R26: accept updates all take effect together
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module dtc_sw_ctrl
  import dtc_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [31:0]          reg_rdata_o,
  input  wire logic                 hw_req_i,
  input  wire logic                 eng_end_i,
  input  wire dtc_result_type       eng_res_i,
  output logic                      eng_start_o,
  output logic                      eng_hw_o,
  output logic      [DTC_PTR_W-1:0] eng_ptr_o,
  output logic                      stop_req_o,
  output logic                      sw_done_irq_o
);

  dtc_state_type        state_r, state_nxt;
  logic [1:0]           dev_r, dev_nxt;
  logic                 pend_r, pend_nxt;
  logic                 done_r, done_nxt;
  logic [DTC_PTR_W-1:0] ptr_r, ptr_nxt;
  logic                 sw_priority_sel_r, sw_priority_sel_nxt;
  logic                 error_stop_enable_r, error_stop_enable_nxt;
  logic [2:0]           est_r, est_nxt;
  logic                 der_r, der_nxt;
  logic                 stop_r, stop_nxt;
  logic [DTC_PTR_W-1:0] eptr_r, eptr_nxt;
  logic                 start_r, start_nxt;
  logic                 hwsel_r, hwsel_nxt;
  logic [31:0]          rdata_r, rdata_nxt;

  // decoded bus, device-state and engine events
  logic wr_trig;
  logic wr_cmd;
  logic wr_cfg;
  logic accept;
  logic is_normal;
  logic end_err;
  logic end_ok;
  logic error_clear_cmd;

  assign wr_trig   = reg_wr_i && (reg_addr_i == DTC_TRIG_OFS);
  assign wr_cmd    = reg_wr_i && (reg_addr_i == DTC_CMD_OFS);
  assign wr_cfg    = reg_wr_i && (reg_addr_i == DTC_CFG_OFS);
  assign is_normal = (dev_r == DTC_ST_NORMAL);
  // trigger admission check
  assign accept    = wr_trig && !pend_r && !stop_r && is_normal; // R2 R23
  assign error_clear_cmd     = wr_cmd && is_normal
                     && (reg_wdata_i[7:0] == DTC_CMD_ERROR_CLEAR_CMD);
  assign end_err   = eng_end_i && (eng_res_i.err_code != DTC_EST_NONE);
  assign end_ok    = eng_end_i && (eng_res_i.err_code == DTC_EST_NONE);

  // next-state logic for arbitration, status and registers
  always_comb begin
    state_nxt = state_r;
    dev_nxt   = dev_r;
    pend_nxt  = pend_r;
    done_nxt  = done_r;
    ptr_nxt   = ptr_r;
    sw_priority_sel_nxt  = sw_priority_sel_r;
    error_stop_enable_nxt  = error_stop_enable_r;
    est_nxt   = est_r;
    der_nxt   = der_r;
    stop_nxt  = stop_r;
    eptr_nxt  = eptr_r;
    start_nxt = 1'b0;
    hwsel_nxt = hwsel_r;

    // device state commands
    case (dev_r)
      DTC_ST_STANDBY: begin
        if (wr_cmd && reg_wdata_i[7:0] == DTC_CMD_RELEASE) begin
          dev_nxt = DTC_ST_TRANS1;
        end
      end
      DTC_ST_TRANS1: begin
        dev_nxt = DTC_ST_NORMAL;
      end
      DTC_ST_NORMAL: begin
        if (wr_cmd && reg_wdata_i[7:0] == DTC_CMD_STANDBY) begin
          dev_nxt  = DTC_ST_TRANS2;
          done_nxt = 1'b0; // standby drops done and its interrupt
        end
      end
      DTC_ST_TRANS2: begin
        if (state_r == DTC_ARB) begin
          dev_nxt = DTC_ST_STANDBY;
        end
      end
      default: begin
        dev_nxt = DTC_ST_STANDBY;
      end
    endcase

    // software-issued clears, applied before hardware sets
    if (wr_cmd && is_normal && reg_wdata_i[7:0] == DTC_CMD_SW_STATUS_CLEAR_CMD) begin
      done_nxt = 1'b0; // R20
    end
    // error clear empties the whole monitor, pointer included
    if (error_clear_cmd) begin
      stop_nxt = 1'b0; // R24
      est_nxt  = DTC_EST_NONE;
      der_nxt  = 1'b0;
      eptr_nxt = DTC_PTR_RESET;
    end
    if (wr_cfg && is_normal) begin
      sw_priority_sel_nxt = reg_wdata_i[DTC_CFG_SW_PRIORITY_SEL_B];
      error_stop_enable_nxt = reg_wdata_i[DTC_CFG_ERROR_STOP_ENABLE_B];
    end

    // trigger write: all updates in the write cycle
    if (accept) begin // R1 R26
      pend_nxt = 1'b1; // R4
      done_nxt = 1'b0; // R21
      ptr_nxt  = reg_wdata_i[DTC_PTR_W-1:0];
    end // otherwise discarded R3

    // error record, first error only
    if (end_err) begin
      // an error in the clear cycle becomes the new record
      if (est_r == DTC_EST_NONE || error_clear_cmd) begin // R9 R25
        est_nxt  = eng_res_i.err_code;
        eptr_nxt = eng_res_i.desc_ptr;
      end else begin
        der_nxt = 1'b1; // R25
      end
      if (error_stop_enable_r) begin
        stop_nxt = 1'b1; // R10 R18
      end
    end

    // arbitration between software and hardware requests
    case (state_r)
      DTC_ARB: begin
        if (is_normal && !stop_r) begin // R10 R18 R24
          if (pend_r && (sw_priority_sel_r || !hw_req_i)) begin // R6 R7
            state_nxt = DTC_SW_RUN;
            start_nxt = 1'b1;
            hwsel_nxt = 1'b0;
          end else if (hw_req_i) begin // R7
            state_nxt = DTC_HW_RUN;
            start_nxt = 1'b1;
            hwsel_nxt = 1'b1;
          end
        end
      end
      DTC_HW_RUN: begin
        // software request waits here until a descriptor ends without a locked chain R5
        if (eng_end_i) begin
          if (end_ok && eng_res_i.chain && eng_res_i.chain_lock
              && dev_r == DTC_ST_NORMAL) begin
            start_nxt = 1'b1; // R8
          end else begin
            state_nxt = DTC_ARB; // R8
          end
        end
      end
      DTC_SW_RUN: begin
        if (end_err) begin
          pend_nxt  = 1'b0; // R17 R19
          state_nxt = DTC_ARB;
        end else if (end_ok && eng_res_i.chain) begin
          ptr_nxt = eng_res_i.next_ptr; // R12
          if (eng_res_i.chain_lock && dev_r == DTC_ST_NORMAL) begin
            start_nxt = 1'b1; // R13
          end else begin
            state_nxt = DTC_ARB; // R13
          end
        end else if (end_ok) begin
          pend_nxt  = 1'b0; // R15 R16
          state_nxt = DTC_ARB;
          if (eng_res_i.irq) begin
            done_nxt = 1'b1; // R14
          end
        end
      end
      default: begin
        state_nxt = DTC_ARB;
      end
    endcase
  end

  // read data, valid only in the cycle after the read strobe
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        DTC_TRIG_OFS: begin
          rdata_nxt[DTC_PTR_W-1:0]   = ptr_r;
          rdata_nxt[DTC_TRIG_PEND_B] = pend_r;
          rdata_nxt[DTC_TRIG_DONE_B] = done_r;
        end
        DTC_CMD_OFS: begin
          rdata_nxt[1:0] = dev_r;
        end
        DTC_CFG_OFS: begin
          rdata_nxt[DTC_CFG_SW_PRIORITY_SEL_B] = sw_priority_sel_r;
          rdata_nxt[DTC_CFG_ERROR_STOP_ENABLE_B] = error_stop_enable_r;
        end
        DTC_MON_OFS: begin
          rdata_nxt[2:0]            = est_r;
          rdata_nxt[DTC_MON_DER_B]  = der_r;
          rdata_nxt[DTC_MON_STOP_B] = stop_r;
          rdata_nxt[31:DTC_MON_PTR_LSB] = eptr_r;
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_r <= DTC_ARB;
      dev_r   <= DTC_ST_STANDBY;
      pend_r  <= 1'b0;
      done_r  <= 1'b0;
      ptr_r   <= DTC_PTR_RESET;
      sw_priority_sel_r  <= DTC_CFG_RESET[DTC_CFG_SW_PRIORITY_SEL_B];
      error_stop_enable_r  <= DTC_CFG_RESET[DTC_CFG_ERROR_STOP_ENABLE_B];
      est_r   <= DTC_EST_NONE;
      der_r   <= 1'b0;
      stop_r  <= 1'b0;
      eptr_r  <= DTC_PTR_RESET;
      start_r <= 1'b0;
      hwsel_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      dev_r   <= dev_nxt;
      pend_r  <= pend_nxt;
      done_r  <= done_nxt;
      ptr_r   <= ptr_nxt;
      sw_priority_sel_r  <= sw_priority_sel_nxt;
      error_stop_enable_r  <= error_stop_enable_nxt;
      est_r   <= est_nxt;
      der_r   <= der_nxt;
      stop_r  <= stop_nxt;
      eptr_r  <= eptr_nxt;
      start_r <= start_nxt;
      hwsel_r <= hwsel_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // outputs
  assign reg_rdata_o   = rdata_r;
  assign eng_start_o   = start_r;
  assign eng_hw_o      = hwsel_r;
  assign eng_ptr_o     = ptr_r; // R11
  assign stop_req_o    = (dev_r == DTC_ST_TRANS2);
  assign sw_done_irq_o = done_r;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_sw_end_ok;
    state_r == DTC_SW_RUN && end_ok;
  endsequence

  sequence s_arb_ready;
    state_r == DTC_ARB && is_normal && !stop_r;
  endsequence

  sequence s_hw_end_ok;
    state_r == DTC_HW_RUN && end_ok;
  endsequence

  a_trig_accept: assert property ( // R2 R4 R26
    wr_trig && !pend_r && !stop_r && is_normal |=>
      pend_r && !done_r && ptr_r == $past(reg_wdata_i[DTC_PTR_W-1:0]))
    else $error("accepted trigger did not update status");

  a_trig_reject: assert property ( // R3 R23
    wr_trig && (pend_r || stop_r || !is_normal) && !eng_end_i |=>
      pend_r == $past(pend_r) && ptr_r == $past(ptr_r))
    else $error("rejected trigger changed status");

  a_sw_prio: assert property ( // R6 R7 R11
    s_arb_ready ##0 (pend_r && (sw_priority_sel_r || !hw_req_i)) |=>
      eng_start_o && !eng_hw_o && eng_ptr_o == $past(ptr_r))
    else $error("software request not started");

  a_hw_prio: assert property ( // R6 R7
    s_arb_ready ##0 (hw_req_i && !(pend_r && sw_priority_sel_r)) |=>
      eng_start_o && eng_hw_o)
    else $error("hardware request not served first");

  a_first_err: assert property ( // R9 R25
    end_err && est_r == DTC_EST_NONE |=>
      est_r == $past(eng_res_i.err_code) && !der_r)
    else $error("first error not recorded");

  a_double_err: assert property ( // R25
    end_err && est_r != DTC_EST_NONE && !error_clear_cmd |=>
      der_r && est_r == $past(est_r) && eptr_r == $past(eptr_r))
    else $error("second error overwrote monitor");

  a_stop_hold: assert property ( // R10 R18
    end_err && error_stop_enable_r |=> stop_r ##0 (!eng_start_o)[*2])
    else $error("error stop did not hold transfers");

  a_sw_chain: assert property ( // R12 R13
    s_sw_end_ok ##0 (eng_res_i.chain && eng_res_i.chain_lock && is_normal)
      |=> eng_start_o && !eng_hw_o && ptr_r == $past(eng_res_i.next_ptr))
    else $error("locked chain did not continue");

  a_sw_irq_end: assert property ( // R14 R15
    s_sw_end_ok ##0 (!eng_res_i.chain && !wr_cmd) |=>
      !pend_r && done_r == ($past(eng_res_i.irq) || $past(done_r)))
    else $error("normal end status wrong");

  a_sw_err_end: assert property ( // R17 R19
    state_r == DTC_SW_RUN && end_err |=> !pend_r && !done_r)
    else $error("error end set done or kept pending");

  // no start of any kind while a hardware descriptor runs
  a_hw_wait: assert property ( // R5
    state_r == DTC_HW_RUN && !eng_end_i |=> !eng_start_o)
    else $error("start issued during hardware descriptor");

  // unchained hardware end hands control back to arbitration
  a_hw_end_arb: assert property ( // R8
    s_hw_end_ok ##0 !eng_res_i.chain |=> state_r == DTC_ARB)
    else $error("hardware end did not rearbitrate");

  // unlocked software chain: new pointer, back to arbitration
  a_sw_chain_free: assert property ( // R12 R13
    s_sw_end_ok ##0 (eng_res_i.chain && !eng_res_i.chain_lock) |=>
      state_r == DTC_ARB && !eng_start_o
      && ptr_r == $past(eng_res_i.next_ptr))
    else $error("unlocked chain did not rearbitrate");

  // error clear without a new error leaves an empty monitor
  a_err_clear: assert property ( // R24
    error_clear_cmd && !end_err |=> !stop_r && est_r == DTC_EST_NONE && !der_r
      && eptr_r == DTC_PTR_RESET)
    else $error("error clear did not empty monitor");

endmodule

// ===== tb/dtc_eng_model.sv
// partner: descriptor engine model, one end per start
`timescale 1ns/1ps
module dtc_eng_model
  import dtc_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 start_i,
  input  wire logic                 hw_i,
  input  wire logic [DTC_PTR_W-1:0] ptr_i,
  input  wire logic [7:0]           lat_i,
  input  wire dtc_result_type       res_i,
  output logic                      end_o,
  output dtc_result_type            res_o
);
  logic [7:0]           cnt_r;
  logic                 busy_r;
  logic                 hw_r;
  logic [DTC_PTR_W-1:0] ptr_r;

  // run lat_i+1 cycles, then end; stale result scrambled between ends
  always_ff @(posedge clock_i) begin
    end_o <= 1'b0;
    res_o <= ~res_o;
    if (!rst_n_i) begin
      busy_r <= 1'b0;
      res_o  <= '0;
    end else if (start_i && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r  <= lat_i;
      hw_r   <= hw_i;
      ptr_r  <= ptr_i;
    end else if (busy_r && cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else if (busy_r) begin
      busy_r <= 1'b0;
      end_o  <= 1'b1;
      res_o  <= res_i;
      if (!hw_r) res_o.desc_ptr <= ptr_r; // software reports its own pointer
    end
  end
endmodule

// ===== tb/tb_dtc_sw_ctrl.sv
// testbench: software trigger, arbitration and error handling
`timescale 1ns/1ps
module tb_dtc_sw_ctrl;
  import dtc_pkg::*;
  logic                 clock_i;
  logic                 rst_n_i;
  logic                 reg_wr_i;
  logic                 reg_rd_i;
  logic                 hw_req_i;
  logic                 eng_end;
  logic                 eng_start_o;
  logic                 eng_hw_o;
  logic                 stop_req_o;
  logic                 sw_done_irq_o;
  logic [7:0]           reg_addr_i;
  logic [7:0]           lat;
  logic [31:0]          reg_wdata_i;
  logic [31:0]          reg_rdata_o;
  logic [31:0]          d;
  logic [DTC_PTR_W-1:0] eng_ptr_o;
  dtc_result_type       res;
  dtc_result_type       eng_res;
  int                   err_count;
  int                   checks;
  int                   n_start;
  int                   n0;

  dtc_sw_ctrl i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .hw_req_i(hw_req_i),
    .eng_end_i(eng_end), .eng_res_i(eng_res), .eng_start_o(eng_start_o),
    .eng_hw_o(eng_hw_o), .eng_ptr_o(eng_ptr_o), .stop_req_o(stop_req_o),
    .sw_done_irq_o(sw_done_irq_o));

  dtc_eng_model i_eng (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .start_i(eng_start_o), .hw_i(eng_hw_o), .ptr_i(eng_ptr_o), .lat_i(lat),
    .res_i(res), .end_o(eng_end), .res_o(eng_res));

  // clock, 40 ns period
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // count every start pulse
  always @(posedge clock_i) begin
    if (eng_start_o === 1'b1) n_start++;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
    d = reg_rdata_o;
  endtask

  task automatic wait_start(input logic hw);
    int i;
    for (i = 0; i < 300 && eng_start_o !== 1'b1; i++) @(posedge clock_i);
    if (i == 300) chk(32'h0, 32'h1);
    chk(eng_hw_o, hw);
  endtask

  task automatic wait_end();
    int i;
    for (i = 0; i < 300 && eng_end !== 1'b1; i++) @(posedge clock_i);
    if (i == 300) chk(32'h0, 32'h1);
    @(posedge clock_i);
  endtask

  // accepted trigger: start with latched pointer, status updated together
  task automatic trig(input logic [15:0] p);
    wr(DTC_TRIG_OFS, {16'h0000, p});
    wait_start(1'b0);
    chk(eng_ptr_o, p);
    rd(DTC_TRIG_OFS);
    chk(d, {15'h0, 1'b1, p});
  endtask

  initial begin
    rst_n_i     = 1'b0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    hw_req_i    = 1'b0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 32'h0;
    lat         = 8'h03;
    res         = '0;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(DTC_CMD_OFS);
    chk(d, 32'h1);
    wr(DTC_TRIG_OFS, 32'h1234);
    rd(DTC_TRIG_OFS);
    chk(d, 32'h0);
    wr(DTC_CMD_OFS, DTC_CMD_RELEASE);
    repeat (2) @(posedge clock_i);
    rd(DTC_CMD_OFS);
    chk(d, 32'h0);
    // normal end with and without interrupt flag
    wr(DTC_CFG_OFS, 32'h1);
    res.irq <= 1'b1;
    trig(16'h0010);
    wait_end();
    rd(DTC_TRIG_OFS);
    chk(d, 32'h0002_0010);
    chk(sw_done_irq_o, 1'b1);
    res.irq <= 1'b0;
    trig(16'h0020);
    chk(sw_done_irq_o, 1'b0);
    wait_end();
    rd(DTC_TRIG_OFS);
    chk(d, 32'h0000_0020);
    // second trigger while pending is discarded
    lat <= 8'h14;
    trig(16'h0030);
    wr(DTC_TRIG_OFS, 32'h0040);
    rd(DTC_TRIG_OFS);
    chk(d, 32'h0001_0030);
    wait_end();
    // locked chain restarts at once with next pointer
    lat <= 8'h04;
    res.chain      <= 1'b1;
    res.chain_lock <= 1'b1;
    res.next_ptr   <= 16'h0055;
    trig(16'h0050);
    wait_end();
    chk(eng_start_o, 1'b1);
    chk(eng_ptr_o, 16'h0055);
    res.chain <= 1'b0;
    wait_end();
    // unlocked chain rearbitrates: hardware first at low priority
    wr(DTC_CFG_OFS, 32'h0);
    res.chain      <= 1'b1;
    res.chain_lock <= 1'b0;
    res.next_ptr   <= 16'h0066;
    trig(16'h0060);
    hw_req_i <= 1'b1;
    wait_end();
    res.chain <= 1'b0;
    wait_start(1'b1);
    hw_req_i <= 1'b0;
    wait_end();
    wait_start(1'b0);
    chk(eng_ptr_o, 16'h0066);
    wait_end();
    // software priority wins once the hardware descriptor ends
    wr(DTC_CFG_OFS, 32'h1);
    hw_req_i <= 1'b1;
    wait_start(1'b1);
    wr(DTC_TRIG_OFS, 32'h0070);
    wait_end();
    wait_start(1'b0);
    chk(eng_ptr_o, 16'h0070);
    hw_req_i <= 1'b0;
    wait_end();
    // first error kept, later one only flagged
    wr(DTC_CFG_OFS, 32'h0);
    res.err_code <= 3'h2;
    res.desc_ptr <= 16'h0077;
    hw_req_i <= 1'b1;
    wait_start(1'b1);
    hw_req_i <= 1'b0;
    wait_end();
    rd(DTC_MON_OFS);
    chk(d, 32'h0077_0002);
    res.err_code <= 3'h5;
    res.irq      <= 1'b1;
    trig(16'h0080);
    wait_end();
    rd(DTC_MON_OFS);
    chk(d, 32'h0077_000a);
    rd(DTC_TRIG_OFS);
    chk(d, 32'h0000_0080);
    // error stop withholds starts until error clear
    wr(DTC_CMD_OFS, DTC_CMD_ERROR_CLEAR_CMD);
    wr(DTC_CFG_OFS, 32'h2);
    res.err_code <= 3'h1;
    trig(16'h0090);
    wait_end();
    rd(DTC_MON_OFS);
    chk(d, 32'h0090_0011);
    hw_req_i <= 1'b1;
    n0 = n_start;
    wr(DTC_TRIG_OFS, 32'h00a0);
    repeat (20) @(posedge clock_i);
    chk(n_start, n0);
    rd(DTC_TRIG_OFS);
    chk(d, 32'h0000_0090);
    res.err_code <= 3'h0;
    wr(DTC_CMD_OFS, DTC_CMD_ERROR_CLEAR_CMD);
    wait_start(1'b1);
    hw_req_i <= 1'b0;
    wait_end();
    rd(DTC_MON_OFS);
    chk(d, 32'h0);
    // unchained end sets done, clear drops it, standby ignores triggers
    trig(16'h00c0);
    wait_end();
    rd(DTC_TRIG_OFS);
    chk(d, 32'h0002_00c0);
    wr(DTC_CMD_OFS, DTC_CMD_SW_STATUS_CLEAR_CMD);
    rd(DTC_TRIG_OFS);
    chk(d, 32'h0000_00c0);
    chk(sw_done_irq_o, 1'b0);
    wr(DTC_CMD_OFS, DTC_CMD_STANDBY);
    @(posedge clock_i);
    chk(stop_req_o, 1'b1);
    repeat (3) @(posedge clock_i);
    chk(stop_req_o, 1'b0);
    rd(DTC_CMD_OFS);
    chk(d, 32'h1);
    wr(DTC_TRIG_OFS, 32'h00b0);
    rd(DTC_TRIG_OFS);
    chk(d, 32'h0000_00c0);
    chk(sw_done_irq_o, 1'b0);
    print_verdict();
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    print_verdict();
  end
endmodule
